/* shared/seq_defines.svh */
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

// Data memory geometry: 16 rows of two 5-bit words
`define SEQ_DM_WORD_W 5
`define SEQ_DM_ROW_W 4
`define SEQ_DM_ADDR_W 5
`define SEQ_NIBBLE_W 4

// Return stack
`define SEQ_SP_W 2
`define SEQ_SP_RESET 2'h0
`define SEQ_SP_LAST 2'h3
`define SEQ_SP_STEP 2'h1
`define SEQ_STACK_TOP_ROW 4'hf

// Table pointer row and upper address bits from the control register
`define SEQ_PTR_ROW 4'h0
`define SEQ_PAGE_W 2

// Program counter arithmetic
`define SEQ_PM_WORDS 1002
`define SEQ_PM_WORD_W 10
`define SEQ_CALL_INC 1
`define SEQ_RET_INC 2
`define SEQ_LEN_W 2

`endif

/* shared/seq_pkg.sv */
package seq_pkg;
  // Gray path: idle -> return wait only; idle -> table wait flips both bits
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_ret_wait = 2'h1,
    st_table_wait = 2'h3
  } seq_state_t;
endpackage

/* shared/dmem_if.sv */
`include "seq_defines.svh"

interface dmem_if;
  logic we_lo;
  logic we_hi;
  logic [`SEQ_DM_ROW_W-1:0] waddr;
  logic [`SEQ_DM_WORD_W-1:0] wdata_lo;
  logic [`SEQ_DM_WORD_W-1:0] wdata_hi;
  logic [`SEQ_DM_ROW_W-1:0] raddr;
  logic [`SEQ_DM_WORD_W-1:0] rdata_lo;
  logic [`SEQ_DM_WORD_W-1:0] rdata_hi;
  modport mem (input we_lo, we_hi, waddr, wdata_lo, wdata_hi, raddr,
    output rdata_lo, rdata_hi);
  modport user (output we_lo, we_hi, waddr, wdata_lo, wdata_hi, raddr,
    input rdata_lo, rdata_hi);
endinterface

/* logic/data_memory.sv */
`include "seq_defines.svh"

module data_memory (
  // Clock
  input wire logic clock,
  // Row port
  dmem_if.mem port
);
  localparam int ROWS = 1 << `SEQ_DM_ROW_W;

  logic [`SEQ_DM_WORD_W-1:0] col_lo [ROWS];
  logic [`SEQ_DM_WORD_W-1:0] col_hi [ROWS];
  logic [`SEQ_DM_WORD_W-1:0] rd_lo_q;
  logic [`SEQ_DM_WORD_W-1:0] rd_hi_q;

  // No reset on the array: contents survive reset, undefined at power-up
  always_ff @(posedge clock) begin
    if (port.we_lo) begin
      col_lo[port.waddr] <= port.wdata_lo;
    end
    if (port.we_hi) begin
      col_hi[port.waddr] <= port.wdata_hi;
    end
    rd_lo_q <= col_lo[port.raddr];
    rd_hi_q <= col_hi[port.raddr];
  end

  assign port.rdata_lo = rd_lo_q;
  assign port.rdata_hi = rd_hi_q;
endmodule // data_memory

/* logic/program_sequencer_stack.sv */
`include "seq_defines.svh"

// Contract
// - Counter sized for 1002 or 512 words
// - Program memory words are 10 bits wide
// - Sequential step adds instruction length
// - Taken jumps load destination address
// - Load immediate or memory into counter bits
// - Call pushes counter plus one, loads target
// - Return loads top entry plus two
// - Reset or all-clear zeroes counter
// - Stack index up on call, down on return
// - Stack index clears, top row first
// - Stack lives in data memory rows
// - Index overflow or underflow resets counter
// - Data memory is 32 five-bit words
// - Data memory kept across reset
// - First row pair points into program memory
// - Pointer gives low eight, page two bits
module program_sequencer_stack import seq_pkg::*; #(
  parameter int PM_WORDS = `SEQ_PM_WORDS,
  parameter int PC_W = $clog2(PM_WORDS)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Decoder requests
  input wire logic all_clear,
  input wire logic step,
  input wire logic [`SEQ_LEN_W-1:0] step_len,
  input wire logic jump_take,
  input wire logic [PC_W-1:0] jump_target,
  input wire logic pc_load,
  input wire logic pc_load_from_mem,
  input wire logic [PC_W-1:0] pc_load_mask,
  input wire logic [PC_W-1:0] pc_load_value,
  input wire logic subroutine_call,
  input wire logic [PC_W-1:0] call_target,
  input wire logic subroutine_return,
  input wire logic table_req,
  input wire logic [`SEQ_PAGE_W-1:0] table_page,
  // Data memory word port
  input wire logic dm_we,
  input wire logic [`SEQ_DM_ADDR_W-1:0] dm_addr,
  input wire logic [`SEQ_DM_WORD_W-1:0] dm_wdata,
  output logic [`SEQ_DM_WORD_W-1:0] dm_rdata,
  // Sequencer state
  output logic busy,
  output logic [PC_W-1:0] program_counter,
  output logic [`SEQ_SP_W-1:0] return_stack_index,
  output logic overrun,
  output logic [`SEQ_PM_WORD_W-1:0] pm_addr,
  output logic table_valid
);
  localparam int RA_W = 2 * `SEQ_DM_WORD_W;

  dmem_if dm ();

  data_memory u_mem (
    .clock(clock),
    .port(dm.mem)
  );

  seq_state_t state_q, state_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [`SEQ_SP_W-1:0] sp_q, sp_d;
  logic ovr_q, ovr_d;
  logic col_q, col_d;
  logic [`SEQ_PAGE_W-1:0] page_q, page_d;
  logic tv_q, tv_d;
  logic [`SEQ_PM_WORD_W-1:0] taddr_q, taddr_d;

  logic idle;
  logic [`SEQ_DM_ROW_W-1:0] push_row, pop_row;
  logic [PC_W-1:0] push_val, mem_val;
  logic [RA_W-1:0] ret_addr;
  logic [PC_W-1:0] ret_pc;

  assign idle = (state_q == st_idle);
  assign busy = !idle;

  // Index 0 is the top row; deeper calls walk down one row each
  assign push_row = `SEQ_STACK_TOP_ROW - `SEQ_DM_ROW_W'(sp_q);
  assign pop_row = `SEQ_STACK_TOP_ROW - `SEQ_DM_ROW_W'(sp_q - `SEQ_SP_STEP);
  assign push_val = pc_q + PC_W'(`SEQ_CALL_INC);
  assign ret_addr = {dm.rdata_hi, dm.rdata_lo};
  assign ret_pc = PC_W'(ret_addr) + PC_W'(`SEQ_RET_INC);
  // Memory nibble is copied to every nibble lane; the mask picks the lane
  assign mem_val = PC_W'({3{dm_rdata[`SEQ_NIBBLE_W-1:0]}});

  // Data memory port: stack push wins over a user write in the same cycle
  always_comb begin
    dm.we_lo = 1'b0;
    dm.we_hi = 1'b0;
    dm.waddr = dm_addr[`SEQ_DM_ADDR_W-1:1];
    dm.wdata_lo = dm_wdata;
    dm.wdata_hi = dm_wdata;
    dm.raddr = dm_addr[`SEQ_DM_ADDR_W-1:1];
    if (idle && !all_clear && subroutine_call) begin
      // Plain overwrite of whatever general data sat in the row
      dm.we_lo = 1'b1;
      dm.we_hi = 1'b1;
      dm.waddr = push_row;
      dm.wdata_lo = `SEQ_DM_WORD_W'(RA_W'(push_val));
      dm.wdata_hi = `SEQ_DM_WORD_W'(RA_W'(push_val) >> `SEQ_DM_WORD_W);
    end else if (dm_we) begin
      dm.we_lo = !dm_addr[0];
      dm.we_hi = dm_addr[0];
    end
    if (idle && !all_clear && subroutine_return) begin
      dm.raddr = pop_row;
    end else if (idle && !all_clear && table_req) begin
      dm.raddr = `SEQ_PTR_ROW;
    end
  end

  assign dm_rdata = col_q ? dm.rdata_hi : dm.rdata_lo;

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    sp_d = sp_q;
    ovr_d = 1'b0;
    col_d = dm_addr[0];
    page_d = page_q;
    tv_d = 1'b0;
    taddr_d = taddr_q;
    if (all_clear) begin
      state_d = st_idle;
      pc_d = '0;
      sp_d = `SEQ_SP_RESET;
    end else begin
      case (state_q)
        st_idle: begin
          if (subroutine_return) begin
            sp_d = sp_q - `SEQ_SP_STEP;
            if (sp_q == `SEQ_SP_RESET) begin
              pc_d = '0;
              ovr_d = 1'b1;
            end else begin
              state_d = st_ret_wait;
            end
          end else if (subroutine_call) begin
            sp_d = sp_q + `SEQ_SP_STEP;
            if (sp_q == `SEQ_SP_LAST) begin
              pc_d = '0;
              ovr_d = 1'b1;
            end else begin
              pc_d = call_target;
            end
          end else if (table_req) begin
            page_d = table_page;
            state_d = st_table_wait;
          end else if (jump_take) begin
            pc_d = jump_target;
          end else if (pc_load) begin
            pc_d = (pc_q & ~pc_load_mask) |
              ((pc_load_from_mem ? mem_val : pc_load_value) & pc_load_mask);
          end else if (step) begin
            pc_d = pc_q + PC_W'(step_len);
          end
        end
        st_ret_wait: begin
          pc_d = ret_pc;
          state_d = st_idle;
        end
        st_table_wait: begin
          // Page bits above the 8-bit pointer from the two row words
          taddr_d = {page_q, dm.rdata_hi[`SEQ_NIBBLE_W-1:0],
            dm.rdata_lo[`SEQ_NIBBLE_W-1:0]};
          tv_d = 1'b1;
          state_d = st_idle;
        end
        default: begin
          state_d = st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= st_idle;
      pc_q <= '0;
      sp_q <= `SEQ_SP_RESET;
      ovr_q <= 1'b0;
      col_q <= 1'b0;
      page_q <= '0;
      tv_q <= 1'b0;
      taddr_q <= '0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      ovr_q <= ovr_d;
      col_q <= col_d;
      page_q <= page_d;
      tv_q <= tv_d;
      taddr_q <= taddr_d;
    end
  end

  assign program_counter = pc_q;
  assign return_stack_index = sp_q;
  assign overrun = ovr_q;
  assign table_valid = tv_q;
  // Table address only shown for the cycle it is valid, else the counter
  assign pm_addr = tv_q ? taddr_q : `SEQ_PM_WORD_W'(pc_q);

  // Checks
  logic ac_n;
  assign ac_n = !all_clear;

  sequence s_call_ok;
    idle && ac_n && subroutine_call && sp_q != `SEQ_SP_LAST;
  endsequence
  sequence s_ret_ok;
    idle && ac_n && subroutine_return && sp_q != `SEQ_SP_RESET;
  endsequence
  sequence s_jump;
    idle && ac_n && !subroutine_call && !subroutine_return && !table_req && jump_take;
  endsequence

  property p_clear;
    @(posedge clock) disable iff (!nrst)
      all_clear |=> pc_q == '0 && sp_q == `SEQ_SP_RESET && state_q == st_idle;
  endproperty
  a_clear: assert property (p_clear) else $error("all-clear did not zero");

  property p_step;
    @(posedge clock) disable iff (!nrst)
      idle && ac_n && step && !subroutine_call && !subroutine_return && !table_req
      && !jump_take && !pc_load |=> pc_q == $past(pc_q) + PC_W'($past(step_len));
  endproperty
  a_step: assert property (p_step) else $error("step length wrong");

  property p_jump;
    @(posedge clock) disable iff (!nrst)
      s_jump |=> pc_q == $past(jump_target);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded");

  property p_call;
    @(posedge clock) disable iff (!nrst)
      s_call_ok |-> dm.we_lo && dm.we_hi && dm.waddr == push_row
      ##1 pc_q == $past(call_target) && sp_q == $past(sp_q) + `SEQ_SP_STEP;
  endproperty
  a_call: assert property (p_call) else $error("call push wrong");

  property p_round_trip;
    @(posedge clock) disable iff (!nrst)
      s_call_ok ##1 (idle && ac_n && subroutine_return && !dm_we) ##1 ac_n
      |=> pc_q == $past(pc_q, 3) + PC_W'(`SEQ_CALL_INC) + PC_W'(`SEQ_RET_INC);
  endproperty
  a_round_trip: assert property (p_round_trip) else $error("return value wrong");

  property p_ret_wait;
    @(posedge clock) disable iff (!nrst)
      s_ret_ok |=> state_q == st_ret_wait && sp_q == $past(sp_q) - `SEQ_SP_STEP
      ##1 (state_q == st_idle);
  endproperty
  a_ret_wait: assert property (p_ret_wait) else $error("return sequence wrong");

  property p_overrun;
    @(posedge clock) disable iff (!nrst)
      idle && ac_n && (subroutine_return ? sp_q == `SEQ_SP_RESET
      : subroutine_call && sp_q == `SEQ_SP_LAST) |=> pc_q == '0 && overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not reset");

  property p_table;
    @(posedge clock) disable iff (!nrst)
      idle && ac_n && !subroutine_call && !subroutine_return && table_req
      |-> dm.raddr == `SEQ_PTR_ROW ##1 (all_clear or ##1 (table_valid
      && pm_addr[`SEQ_PM_WORD_W-1 -: `SEQ_PAGE_W] == $past(table_page, 2)));
  endproperty
  a_table: assert property (p_table) else $error("table address wrong");
endmodule // program_sequencer_stack

/* bench/pm_model.sv */
`include "seq_defines.svh"

module pm_model (
  // Fetch address
  input wire logic [`SEQ_PM_WORD_W-1:0] pm_addr,
  // Word at that address
  output logic [`SEQ_PM_WORD_W-1:0] pm_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // Fixed pattern of the address, so a wrong fetch shows as a wrong word
  assign pm_word = pm_addr ^ 10'h2a5;
endmodule // pm_model

/* bench/program_sequencer_stack_tb.sv */
module program_sequencer_stack_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, nrst = 0, all_clear, step, jump_take, pc_load, pc_load_from_mem;
  logic subroutine_call, subroutine_return, table_req, dm_we, busy, overrun, table_valid;
  logic [1:0] step_len, table_page, return_stack_index;
  logic [9:0] jump_target, pc_load_mask, pc_load_value, call_target;
  logic [9:0] program_counter, pm_addr, pm_word;
  logic [4:0] dm_addr, dm_wdata, dm_rdata;
  int miscompares = 0, n_checks = 0;

  always #10 clock = ~clock;

  program_sequencer_stack program_sequencer_stack_inst (.clock(clock), .nrst(nrst),
    .all_clear(all_clear), .step(step), .step_len(step_len), .jump_take(jump_take),
    .jump_target(jump_target), .pc_load(pc_load), .pc_load_from_mem(pc_load_from_mem),
    .pc_load_mask(pc_load_mask), .pc_load_value(pc_load_value),
    .subroutine_call(subroutine_call), .call_target(call_target),
    .subroutine_return(subroutine_return), .table_req(table_req), .table_page(table_page),
    .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
    .busy(busy), .program_counter(program_counter),
    .return_stack_index(return_stack_index), .overrun(overrun), .pm_addr(pm_addr),
    .table_valid(table_valid));
  pm_model pm_model_inst (.pm_addr(pm_addr), .pm_word(pm_word));

  task close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input logic [9:0] seen, input logic [9:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // Every task starts and ends at a falling edge
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask

  task wr(input logic [4:0] a, input logic [4:0] d);
    dm_addr = a;
    dm_wdata = d;
    dm_we = 1'b1;
    @(negedge clock);
    dm_we = 1'b0;
    // One idle edge so two writes in a row never toggle dm_we in one step
    @(negedge clock);
  endtask

  // Two edges so a write landing on the first edge is surely seen
  task rd(input logic [4:0] a, input logic [4:0] want);
    dm_addr = a;
    repeat (2) @(negedge clock);
    check(dm_rdata, want);
  endtask

  task wait_level(input logic want_busy, input logic want_valid);
    for (int k = 0; busy !== want_busy || table_valid !== want_valid; k++) begin
      if (k == 8) begin
        miscompares++;
        close_out();
      end
      @(negedge clock);
    end
  endtask

  task do_reset;
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
  endtask

  task t_reset_memory;
    wr(5'h03, 5'h15);
    wr(5'h1c, 5'h0a);
    do_reset();
    check(program_counter, 10'h000);
    check(return_stack_index, 2'h0);
    check(10'($bits(program_counter)), 10'h00a);
    rd(5'h03, 5'h15);
    rd(5'h1c, 5'h0a);
  endtask

  task t_step_jump_load;
    step_len = 2'h1;
    step = 1'b1;
    @(negedge clock);
    check(program_counter, 10'h001);
    step_len = 2'h2;
    @(negedge clock);
    step = 1'b0;
    check(program_counter, 10'h003);
    jump_target = 10'h3e7;
    pulse(jump_take);
    check(program_counter, 10'h3e7);
    pc_load_mask = 10'h0f0;
    pc_load_value = 10'h25a;
    pulse(pc_load);
    check(program_counter, 10'h357);
    wr(5'h00, 5'h1c);
    @(negedge clock);
    pc_load_from_mem = 1'b1;
    pc_load_mask = 10'h00f;
    pulse(pc_load);
    pc_load_from_mem = 1'b0;
    check(program_counter, 10'h35c);
  endtask

  task t_call_return;
    call_target = 10'h080;
    pulse(subroutine_call);
    check(program_counter, 10'h080);
    check(return_stack_index, 2'h1);
    rd(5'h1e, 5'h1d);
    rd(5'h1f, 5'h1a);
    call_target = 10'h0c0;
    pulse(subroutine_call);
    check(return_stack_index, 2'h2);
    // Return right after the call, so the fresh push is read back at once
    pulse(subroutine_return);
    check(busy, 1'b1);
    wait_level(1'b0, 1'b0);
    check(program_counter, 10'h083);
    check(return_stack_index, 2'h1);
    rd(5'h1c, 5'h01);
    pulse(subroutine_return);
    check(busy, 1'b1);
    // A jump offered in the wait cycle must be ignored
    jump_target = 10'h111;
    pulse(jump_take);
    wait_level(1'b0, 1'b0);
    check(program_counter, 10'h35f);
  endtask

  task t_overrun;
    pulse(subroutine_return);
    check(overrun, 1'b1);
    check(program_counter, 10'h000);
    check(return_stack_index, 2'h3);
    jump_target = 10'h111;
    pulse(jump_take);
    check(overrun, 1'b0);
    pulse(all_clear);
    check(program_counter, 10'h000);
    check(return_stack_index, 2'h0);
    call_target = 10'h200;
    // Held for four edges: three pushes fill the top rows, the fourth overflows
    subroutine_call = 1'b1;
    repeat (3) @(negedge clock);
    check(return_stack_index, 2'h3);
    @(negedge clock);
    subroutine_call = 1'b0;
    check(overrun, 1'b1);
    check(program_counter, 10'h000);
  endtask

  task t_table;
    wr(5'h00, 5'h0b);
    wr(5'h01, 5'h06);
    table_page = 2'h2;
    pulse(table_req);
    wait_level(1'b0, 1'b1);
    check(pm_addr, 10'h26b);
    check(pm_word, 10'h0ce);
    @(negedge clock);
    check(pm_addr, 10'h000);
    check(table_valid, 1'b0);
  endtask

  initial begin
    {all_clear, step, jump_take, pc_load, pc_load_from_mem} = '0;
    {subroutine_call, subroutine_return, table_req, dm_we} = '0;
    {step_len, table_page, jump_target, pc_load_mask, pc_load_value} = '0;
    {call_target, dm_addr, dm_wdata} = '0;
    do_reset();
    t_reset_memory();
    t_step_jump_load();
    t_call_return();
    t_overrun();
    t_table();
    close_out();
  end
endmodule // program_sequencer_stack_tb
